// ---- src/peer_block_index_window.sv ----
/*
 * APB register bank for one peer connection block: status code, index
 * pointer, data window onto the peer data array and special parameters,
 * plus element count and poll period registers.
 * Assumes a protocol engine on the same pclk that reports events, fills the
 * array and reads it back for block writes.
 */
// The APB slave port and the address map are this design's own decisions.
// Contract
// - status reads 0 while no peer connection exists
// - status reads 1 after success, -1 after failure
// - status reads -2 connecting, -3 reading, -4 writing
// - status reads -10 when operation aborted for lack of resources
// - index 0 addresses start element, higher indices the next elements
// - index writes accepted any time once the count is initialised
// - window backed by array sized by count, addressed by index
// - index 1000 and above selects special parameters, writable via window
// - index 1000 is request timeout: 500 ms single, 2.5 poll periods polled
// - timed-out requests retried only while poll period nonzero
// - on failure status is not 1 and index 1001 gives failing offset
// - index 1002 is writable retry counter, plus one per timeout
// - index 1003 selects protocol, 0 default, 2 for client mode
// - index 1004 holds destination TCP port, default 502
// - index 1005 holds unit id, default 0, used by later requests
// - index 1006 returns last received exception code
// - selecting index 1999 starts a whole block write to the peer
// - indices 2000 to 2099 address staging elements from offset 0
// - polled updates leave data alone while index is in 2XXX range
// - count ranges from 1 up to 100 elements
// - status falls to 0 without refresh within 2.5 poll periods
`timescale 1ns/100ps
`default_nettype none
`include "peer_win_cfg.svh"

module peer_block_index_window #(
  parameter int MAX_ELEMS  = `MAX_ELEMS,
  parameter int CYC_PER_MS = `CYC_PER_MS
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   eng_evt,
  input  wire peer_win_pkg::peer_evt_e eng_code,
  input  wire logic [31:0]            eng_fail_off,
  input  wire logic                   eng_tmo,
  input  wire logic                   eng_exc_vld,
  input  wire logic [31:0]            eng_exc_code,
  input  wire logic                   eng_rx_we,
  input  wire logic [6:0]             eng_rx_idx,
  input  wire logic [31:0]            eng_rx_data,
  input  wire logic [6:0]             eng_rd_idx,
  output logic [31:0]                 eng_rd_data,
  output logic                        blk_wr_start,
  output logic                        one_wr_start,
  output logic [6:0]                  one_wr_idx,
  output logic                        conn_reset,
  output logic                        retry_en,
  output logic [31:0]                 tmo_ms,
  output logic [31:0]                 proto,
  output logic [31:0]                 tcp_port,
  output logic [31:0]                 unit_id,
  output logic [7:0]                  elem_count
);
  import peer_win_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] index;
    logic [7:0]  count;
    logic        count_init;
    logic [31:0] poll;
    logic [31:0] tmo_val;
    logic        tmo_set;
    logic [31:0] tmo_eff;
    logic [31:0] fail_off;
    logic [31:0] retry;
    logic        retry_en;
    logic [31:0] proto;
    logic [31:0] port;
    logic [31:0] unit;
    logic [31:0] exc;
    logic [31:0] ms_cnt;
    logic [31:0] wd_ms;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        blk_wr;
    logic        one_wr;
    logic [6:0]  one_idx;
    logic        conn_rst;
    logic [31:0] rd_data;
  } regs_s;

  regs_s       st_ff;
  regs_s       nxt_st;
  logic [31:0] mem [MAX_ELEMS];

  // ****************************************************************
  // window decode
  // ****************************************************************
  function automatic win_e win_kind(input logic [31:0] idx, input logic [7:0] cnt);
    win_e k;
    k = W_NONE;
    if (idx < {24'h00_0000, cnt})
      k = W_ARR;
    else if (idx == `IDX_TMO)
      k = W_TMO;
    else if (idx == `IDX_FAIL)
      k = W_FAIL;
    else if (idx == `IDX_RETRY)
      k = W_RETRY;
    else if (idx == `IDX_PROTO)
      k = W_PROTO;
    else if (idx == `IDX_PORT)
      k = W_PORT;
    else if (idx == `IDX_UNIT)
      k = W_UNIT;
    else if (idx == `IDX_EXC)
      k = W_EXC;
    else if (idx >= `IDX_STAGE_LO && idx <= `IDX_STAGE_HI &&
             (idx - `IDX_STAGE_LO) < {24'h00_0000, cnt})
      k = W_STAGE;
    return k;
  endfunction

  win_e        kind;
  logic [6:0]  arr_idx;
  logic        in_2xxx;
  logic        acc;
  logic        commit;
  logic [34:0] poll_x5;
  logic [31:0] poll_2p5;
  logic        ms_tick;

  always_comb begin
    kind     = win_kind(st_ff.index, st_ff.count);
    arr_idx  = (kind == W_STAGE) ? 7'(st_ff.index - `IDX_STAGE_LO) : 7'(st_ff.index);
    in_2xxx  = st_ff.index >= `IDX_2XXX_LO && st_ff.index <= `IDX_2XXX_HI;
    acc      = psel & penable;
    commit   = acc & st_ff.pready & pwrite & ~st_ff.pslverr;
    poll_x5  = {3'b000, st_ff.poll} + {1'b0, st_ff.poll, 2'b00};
    poll_2p5 = 32'(poll_x5 >> 1);
    ms_tick  = st_ff.ms_cnt == 32'(CYC_PER_MS - 1);
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.blk_wr   = 1'b0;
    nxt_st.one_wr   = 1'b0;
    nxt_st.conn_rst = 1'b0;

    // bus answer: one wait state, read data and error registered
    if (acc && !st_ff.pready) begin
      nxt_st.pready  = 1'b1;
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata  = 32'h0000_0000;
      case (paddr)
        `OFS_STATUS: nxt_st.prdata = st_ff.status;
        `OFS_INDEX:  nxt_st.prdata = st_ff.index;
        `OFS_COUNT:  nxt_st.prdata = {24'h00_0000, st_ff.count};
        `OFS_POLL:   nxt_st.prdata = st_ff.poll;
        `OFS_DATA: begin
          case (kind)
            W_ARR, W_STAGE: nxt_st.prdata = mem[arr_idx];
            W_TMO:          nxt_st.prdata = st_ff.tmo_eff;
            W_FAIL:         nxt_st.prdata = st_ff.fail_off;
            W_RETRY:        nxt_st.prdata = st_ff.retry;
            W_PROTO:        nxt_st.prdata = st_ff.proto;
            W_PORT:         nxt_st.prdata = st_ff.port;
            W_UNIT:         nxt_st.prdata = st_ff.unit;
            W_EXC:          nxt_st.prdata = st_ff.exc;
            default:        nxt_st.prdata = 32'h0000_0000;
          endcase
        end
        default: nxt_st.pslverr = 1'b1;
      endcase
    end else begin
      nxt_st.pready  = 1'b0;
      nxt_st.pslverr = 1'b0;
    end

    // millisecond tick and refresh watchdog
    nxt_st.ms_cnt = ms_tick ? 32'h0000_0000 : st_ff.ms_cnt + 32'h0000_0001;
    if (ms_tick && st_ff.wd_ms != 32'hffff_ffff)
      nxt_st.wd_ms = st_ff.wd_ms + 32'h0000_0001;

    // engine reports
    if (eng_evt) begin
      case (eng_code)
        EV_OFFLINE: nxt_st.status = `ST_OFFLINE;
        EV_DONE: begin
          nxt_st.status = `ST_DONE;
          nxt_st.wd_ms  = 32'h0000_0000;
        end
        EV_FAIL: begin
          nxt_st.status   = `ST_FAIL;
          nxt_st.fail_off = eng_fail_off;
        end
        EV_CONNECT: nxt_st.status = `ST_CONNECT;
        EV_READ:    nxt_st.status = `ST_READ;
        EV_WRITE:   nxt_st.status = `ST_WRITE;
        EV_ABORT:   nxt_st.status = `ST_ABORT;
        default:    nxt_st.status = st_ff.status;
      endcase
    end else if (st_ff.poll != 32'h0000_0000 && st_ff.status == `ST_DONE &&
                 st_ff.wd_ms >= poll_2p5) begin
      nxt_st.status = `ST_OFFLINE;
    end
    if (eng_exc_vld)
      nxt_st.exc = eng_exc_code;

    // software writes
    if (commit) begin
      case (paddr)
        `OFS_INDEX: begin
          if (st_ff.count_init) begin
            nxt_st.index = pwdata;
            if (pwdata == `IDX_BLK_WR)
              nxt_st.blk_wr = 1'b1;
          end
        end
        `OFS_COUNT: begin
          if (pwdata == 32'h0000_0000)
            nxt_st.count = `COUNT_DEF;
          else if (pwdata > 32'(MAX_ELEMS))
            nxt_st.count = 8'(MAX_ELEMS);
          else
            nxt_st.count = 8'(pwdata);
          nxt_st.count_init = 1'b1;
          nxt_st.conn_rst   = 1'b1;
          nxt_st.status     = `ST_OFFLINE;
        end
        `OFS_POLL: begin
          nxt_st.poll  = pwdata;
          nxt_st.wd_ms = 32'h0000_0000;
        end
        `OFS_DATA: begin
          case (kind)
            W_ARR: begin
              nxt_st.one_wr  = 1'b1;
              nxt_st.one_idx = arr_idx;
            end
            W_TMO: begin
              nxt_st.tmo_val = pwdata;
              nxt_st.tmo_set = 1'b1;
            end
            W_RETRY: nxt_st.retry = pwdata;
            W_PROTO: nxt_st.proto = pwdata;
            W_PORT:  nxt_st.port  = pwdata;
            W_UNIT:  nxt_st.unit  = pwdata;
            default: nxt_st.index = st_ff.index;
          endcase
        end
        default: nxt_st.index = nxt_st.index;
      endcase
    end

    // a timeout in the same cycle as a software store adds one to the stored value
    if (eng_tmo)
      nxt_st.retry = nxt_st.retry + 32'h0000_0001;

    // effective timeout and retry permission
    if (st_ff.tmo_set)
      nxt_st.tmo_eff = st_ff.tmo_val;
    else if (st_ff.poll != 32'h0000_0000)
      nxt_st.tmo_eff = poll_2p5;
    else
      nxt_st.tmo_eff = `TMO_DEF_MS;
    nxt_st.retry_en = st_ff.poll != 32'h0000_0000;

    nxt_st.rd_data = mem[eng_rd_idx];
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff            <= '0;
      st_ff.status     <= `ST_OFFLINE;
      st_ff.count      <= `COUNT_DEF;
      st_ff.tmo_val    <= `TMO_DEF_MS;
      st_ff.tmo_eff    <= `TMO_DEF_MS;
      st_ff.proto      <= `PROTO_DEF;
      st_ff.port       <= `PORT_DEF;
      st_ff.unit       <= `UNIT_DEF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // element array
  // ****************************************************************
  always_ff @(posedge pclk) begin
    if (commit && paddr == `OFS_DATA && (kind == W_ARR || kind == W_STAGE))
      mem[arr_idx] <= pwdata;
    else if (eng_rx_we && !in_2xxx && {1'b0, eng_rx_idx} < st_ff.count)
      mem[eng_rx_idx] <= eng_rx_data;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata       = st_ff.prdata;
  assign pready       = st_ff.pready;
  assign pslverr      = st_ff.pslverr;
  assign eng_rd_data  = st_ff.rd_data;
  assign blk_wr_start = st_ff.blk_wr;
  assign one_wr_start = st_ff.one_wr;
  assign one_wr_idx   = st_ff.one_idx;
  assign conn_reset   = st_ff.conn_rst;
  assign retry_en     = st_ff.retry_en;
  assign tmo_ms       = st_ff.tmo_eff;
  assign proto        = st_ff.proto;
  assign tcp_port     = st_ff.port;
  assign unit_id      = st_ff.unit;
  assign elem_count   = st_ff.count;

endmodule
`default_nettype wire

// ---- common/peer_win_cfg.svh ----
/*
 * Constants for the peer block index window: register offsets, reset values,
 * window index codes, status codes and timing figures.
 * Assumes a 32-bit APB register bus and a 100 MHz pclk.
 */
`ifndef PEER_WIN_CFG_SVH
`define PEER_WIN_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_STATUS      8'h00
`define OFS_INDEX       8'h04
`define OFS_DATA        8'h08
`define OFS_COUNT       8'h0c
`define OFS_POLL        8'h10

// ****************************************************************
// window index codes
// ****************************************************************
`define IDX_TMO         32'h0000_03e8
`define IDX_FAIL        32'h0000_03e9
`define IDX_RETRY       32'h0000_03ea
`define IDX_PROTO       32'h0000_03eb
`define IDX_PORT        32'h0000_03ec
`define IDX_UNIT        32'h0000_03ed
`define IDX_EXC         32'h0000_03ee
`define IDX_BLK_WR      32'h0000_07cf
`define IDX_STAGE_LO    32'h0000_07d0
`define IDX_STAGE_HI    32'h0000_0833
`define IDX_2XXX_LO     32'h0000_07d0
`define IDX_2XXX_HI     32'h0000_0bb7

// ****************************************************************
// status codes
// ****************************************************************
`define ST_OFFLINE      32'h0000_0000
`define ST_DONE         32'h0000_0001
`define ST_FAIL         32'hffff_ffff
`define ST_CONNECT      32'hffff_fffe
`define ST_READ         32'hffff_fffd
`define ST_WRITE        32'hffff_fffc
`define ST_ABORT        32'hffff_fff6

// ****************************************************************
// reset values and limits
// ****************************************************************
`define MAX_ELEMS       100
`define TMO_DEF_MS      32'h0000_01f4
`define PROTO_DEF       32'h0000_0000
`define PORT_DEF        32'h0000_01f6
`define UNIT_DEF        32'h0000_0000
`define COUNT_DEF       8'h01

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ          100000000
`define MS_PER_S        1000
`define CYC_PER_MS      (`CLK_HZ / `MS_PER_S)

`endif

// ---- common/peer_win_pkg.sv ----
/*
 * Types shared by the peer block index window and its bench.
 * Assumes nothing beyond a SystemVerilog tool.
 */
package peer_win_pkg;

  // engine event codes, one per status the engine can report
  typedef enum logic [2:0] {
    EV_OFFLINE,
    EV_DONE,
    EV_FAIL,
    EV_CONNECT,
    EV_READ,
    EV_WRITE,
    EV_ABORT
  } peer_evt_e;

  // what the data window currently addresses
  typedef enum logic [3:0] {
    W_ARR,
    W_TMO,
    W_FAIL,
    W_RETRY,
    W_PROTO,
    W_PORT,
    W_UNIT,
    W_EXC,
    W_STAGE,
    W_NONE
  } win_e;

endpackage

// ---- sim/peer_win_asserts.sv ----
/* checker for the peer window register bank.
   bound to the top module by the bench; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
`include "peer_win_cfg.svh"
module peer_win_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        blk_wr_start,
  input wire logic        retry_en,
  input wire logic [31:0] tcp_port,
  input wire logic [7:0]  elem_count
);
  logic       acc;
  logic       blk_req;
  logic [7:0] cnt_exp;
  assign acc = psel && penable && pready;
  assign blk_req = acc && pwrite && paddr == `OFS_INDEX && pwdata == `IDX_BLK_WR;
  always_comb begin
    cnt_exp = (pwdata == 32'h0) ? 8'h01 : (pwdata > 32'h64) ? 8'h64 : pwdata[7:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************
  // bus timing
  // ****************
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  wait_state_a: assert property (psel && !penable |-> ##2 pready)
    else $error("pready not in second access cycle");
  decode_err_a: assert property (acc && paddr[1:0] == 2'h0 |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
    else $error("wrong error response");
  err_data_a: assert property (acc && pslverr |-> prdata == 32'h0)
    else $error("read data not zero on error");
  // ****************
  // register effects
  // ****************
  status_code_a: assert property (acc && !pwrite && paddr == `OFS_STATUS |->
    prdata inside {`ST_OFFLINE, `ST_DONE, `ST_FAIL, `ST_CONNECT, `ST_READ, `ST_WRITE,
    `ST_ABORT}) else $error("illegal status code");
  block_start_a: assert property (blk_wr_start |-> $past(blk_req))
    else $error("block write without index write");
  retry_gate_a: assert property (acc && pwrite && paddr == `OFS_POLL |->
    ##2 retry_en == ($past(pwdata, 2) != 32'h0)) else $error("retry enable wrong");
  count_clamp_a: assert property (acc && pwrite && paddr == `OFS_COUNT |=>
    elem_count == $past(cnt_exp)) else $error("element count not clamped");
  port_hold_a: assert property (!$stable(tcp_port) |->
    $past(acc) && $past(pwrite) && $past(paddr) == `OFS_DATA)
    else $error("port changed without window write");
endmodule
`default_nettype wire

// ---- sim/peer_engine_model.sv ----
/* behavioural protocol engine facing the register bank.
   the bench calls act; pclk comes from the bench. */
`timescale 1ns/100ps
`default_nettype none
module peer_engine_model (
  input  wire logic                pclk,
  output logic                     eng_evt,
  output peer_win_pkg::peer_evt_e  eng_code,
  output logic [31:0]              eng_fail_off,
  output logic                     eng_tmo,
  output logic                     eng_exc_vld,
  output logic [31:0]              eng_exc_code,
  output logic                     eng_rx_we,
  output logic [6:0]               eng_rx_idx,
  output logic [31:0]              eng_rx_data
);
  import peer_win_pkg::*;
  initial begin
    eng_evt = 1'b0;
    eng_code = EV_OFFLINE;
    eng_fail_off = 32'h0;
    eng_tmo = 1'b0;
    eng_exc_vld = 1'b0;
    eng_exc_code = 32'h0;
    eng_rx_we = 1'b0;
    eng_rx_idx = 7'h0;
    eng_rx_data = 32'h0;
  end
  // k: bit0 event, bit1 timeout, bit2 exception, bit3 element write
  task automatic act(input logic [3:0] k, input peer_evt_e c, input logic [31:0] v,
                     input logic [6:0] i, input int gap);
    repeat (gap + 1) @(posedge pclk);
    eng_evt <= k[0];
    eng_tmo <= k[1];
    eng_exc_vld <= k[2];
    eng_rx_we <= k[3];
    eng_code <= c;
    eng_fail_off <= v;
    eng_exc_code <= v;
    eng_rx_data <= v;
    eng_rx_idx <= i;
    @(posedge pclk);
    eng_evt <= 1'b0;
    eng_tmo <= 1'b0;
    eng_exc_vld <= 1'b0;
    eng_rx_we <= 1'b0;
    eng_fail_off <= ~v;
    eng_exc_code <= ~v;
    eng_rx_data <= ~v;
  endtask
endmodule
`default_nettype wire

// ---- sim/peer_block_index_window_tb_top.sv ----
/* bench for the peer window register bank: apb master tasks, engine
   model and register sequences. assumes the shared package and header. */
`timescale 1ns/100ps
`default_nettype none
`include "peer_win_cfg.svh"
module peer_block_index_window_tb_top;
  import peer_win_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, erv;
  logic        eng_evt, eng_tmo, eng_exc_vld, eng_rx_we, retry_en;
  logic        blk_wr_start, one_wr_start, conn_reset;
  logic [6:0]  eng_rx_idx, eng_rd_idx, one_wr_idx;
  logic [7:0]  paddr, elem_count;
  logic [31:0] pwdata, prdata, eng_fail_off, eng_exc_code, eng_rx_data, eng_rd_data;
  logic [31:0] tmo_ms, proto, tcp_port, unit_id, rdv;
  peer_evt_e   eng_code;
  int          errors, comparisons, cycles;
  peer_evt_e   evs[7] = '{EV_CONNECT, EV_READ, EV_WRITE, EV_DONE, EV_FAIL, EV_ABORT,
                          EV_OFFLINE};
  logic [31:0] sts[7] = '{`ST_CONNECT, `ST_READ, `ST_WRITE, `ST_DONE, `ST_FAIL,
                          `ST_ABORT, `ST_OFFLINE};
  logic [31:0] dix[4] = '{`IDX_TMO, `IDX_PROTO, `IDX_PORT, `IDX_UNIT};
  logic [31:0] dfl[4] = '{`TMO_DEF_MS, `PROTO_DEF, `PORT_DEF, `UNIT_DEF};
  logic [31:0] cin[3] = '{32'h0, 32'hc8, 32'h4};
  logic [31:0] cex[3] = '{32'h1, 32'h64, 32'h4};

  peer_block_index_window #(.CYC_PER_MS(10)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .eng_evt, .eng_code,
    .eng_fail_off, .eng_tmo, .eng_exc_vld, .eng_exc_code, .eng_rx_we, .eng_rx_idx,
    .eng_rx_data, .eng_rd_idx, .eng_rd_data, .blk_wr_start, .one_wr_start, .one_wr_idx,
    .conn_reset, .retry_en, .tmo_ms, .proto, .tcp_port, .unit_id, .elem_count);
  peer_engine_model eng (.pclk, .eng_evt, .eng_code, .eng_fail_off, .eng_tmo,
    .eng_exc_vld, .eng_exc_code, .eng_rx_we, .eng_rx_idx, .eng_rx_data);

  always #5 pclk = ~pclk;
  // ****************
  // report
  // ****************
  task automatic summarize;
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize;
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ****************
  // apb master
  // ****************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) errors++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rdv, e);
  endtask
  task automatic wwin(input logic [31:0] i, input logic [31:0] d);
    wr(`OFS_INDEX, i);
    wr(`OFS_DATA, d);
  endtask
  task automatic cwin(input logic [31:0] i, input logic [31:0] e);
    wr(`OFS_INDEX, i);
    chk(`OFS_DATA, e);
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    eng_rd_idx = 7'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk(`OFS_STATUS, `ST_OFFLINE);
    wr(`OFS_INDEX, 32'h5);
    chk(`OFS_INDEX, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(`OFS_COUNT, cin[k]);
      @(negedge pclk);
      cmp({24'h0, elem_count}, cex[k]);
      cmp({31'h0, conn_reset}, 32'h1);
    end
    for (int k = 0; k < 4; k++) cwin(dix[k], dfl[k]);
    wwin(`IDX_PROTO, 32'h2);
    wwin(`IDX_PORT, 32'h5dc);
    wwin(`IDX_UNIT, 32'h7);
    wr(`OFS_POLL, 32'h14);
    cwin(`IDX_TMO, 32'h32);
    @(negedge pclk);
    cmp(proto, 32'h2);
    cmp(tcp_port, 32'h5dc);
    cmp(unit_id, 32'h7);
    cmp({31'h0, retry_en}, 32'h1);
    cmp(tmo_ms, 32'h32);
    wr(`OFS_POLL, 32'h0);
    wwin(`IDX_TMO, 32'h12c);
    cwin(`IDX_TMO, 32'h12c);
    @(negedge pclk);
    cmp(tmo_ms, 32'h12c);
    for (int k = 0; k < 7; k++) begin
      eng.act(4'h1, evs[k], 32'h19, 7'h0, k);
      chk(`OFS_STATUS, sts[k]);
    end
    cwin(`IDX_FAIL, 32'h19);
    wwin(`IDX_RETRY, 32'h5);
    eng.act(4'h2, EV_OFFLINE, 32'h0, 7'h0, 0);
    cwin(`IDX_RETRY, 32'h6);
    eng.act(4'h4, EV_OFFLINE, 32'h3, 7'h0, 0);
    cwin(`IDX_EXC, 32'h3);
    for (int k = 0; k < 4; k++) begin
      wwin(32'(k), 32'ha0 + 32'(k));
      @(negedge pclk);
      cmp({24'h0, one_wr_start, one_wr_idx}, {24'h0, 1'b1, 7'(k)});
    end
    for (int k = 0; k < 4; k++) cwin(32'(k), 32'ha0 + 32'(k));
    wwin(32'h4, 32'hbad0);
    @(negedge pclk);
    cmp({31'h0, one_wr_start}, 32'h0);
    cwin(32'h4, 32'h0);
    eng.act(4'h8, EV_OFFLINE, 32'h77, 7'h2, 0);
    cwin(32'h2, 32'h77);
    wwin(`IDX_STAGE_LO + 32'h1, 32'h55);
    eng.act(4'h8, EV_OFFLINE, 32'h66, 7'h1, 2);
    cwin(`IDX_STAGE_LO + 32'h1, 32'h55);
    wr(`OFS_INDEX, `IDX_BLK_WR);
    eng_rd_idx <= 7'h1;
    @(negedge pclk);
    cmp({31'h0, blk_wr_start}, 32'h1);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    cmp(eng_rd_data, 32'h55);
    apb(1'b0, 8'h14, 32'h0);
    cmp({31'h0, erv}, 32'h1);
    cmp(rdv, 32'h0);
    wr(`OFS_POLL, 32'h4);
    eng.act(4'h1, EV_DONE, 32'h0, 7'h0, 0);
    chk(`OFS_STATUS, `ST_DONE);
    repeat (120) @(posedge pclk);
    chk(`OFS_STATUS, `ST_OFFLINE);
    summarize;
  end
endmodule

bind peer_block_index_window peer_win_asserts u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .blk_wr_start, .retry_en,
  .tcp_port, .elem_count);
`default_nettype wire
